/* File: core/lpm_cfg.svh */
// constants for the transceiver low-power mode controller
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
// control bit positions in the management register image
`define PSAVE_BIT 10
`define ENERGY_PD_BIT 11
`define PLLOFF_BIT 4
`define PDOWN_BIT 11
`define SLOWOSC_BIT 5
`define SWRESET_BIT 15
// reset values of the control bits
`define PSAVE_RST 1'h0
`define ENERGY_PD_N_RST 1'h1
`define PLLOFF_RST 1'h0
`define PDOWN_RST 1'h0
`define SLOWOSC_RST 1'h0
// link pulse interval in microseconds, normal and stretched
`define LP_INTERVAL_US 16
`define LP_LONG_INTERVAL_US 256
`define CLK_MHZ 200
// software reset pulse length in cycles
`define SWRST_CYCLES 4'h8
// gate enables out of reset: all on, reference from the crystal input
`define GATE_ON 7'h7D
`endif

/* File: core/lpm_pkg.sv */
// types for the transceiver low-power mode controller
`default_nettype none
package lpm_pkg;
	typedef enum logic [4:0] {
		ST_NORMAL = 5'h01,
		ST_PSAVE = 5'h02,
		ST_ENERGY_PD = 5'h04,
		ST_PDOWN = 5'h08,
		ST_SLOW = 5'h10
	} pwr_state_type;
	// enables toward the analogue and clock parts
	typedef struct packed {
		logic rx_en;
		logic tx_en;
		logic energy_det_en;
		logic pll_en;
		logic dsp_en;
		logic ref_clk_sel;
		logic core_en;
	} pwr_gate_type;
	// control bits as written by the management host
	typedef struct packed {
		logic psave;
		logic energy_detect_powerdown_n;
		logic pll_off;
		logic pdown;
		logic slow_osc;
	} pwr_ctrl_type;
endpackage
`default_nettype wire

/* File: core/phy_low_power_mode_control.sv */
// power-mode sequencer for a 10/100 transceiver
// ==============================================
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module phy_low_power_mode_control
	import lpm_pkg::*;
#(
	// link pulse spacing in clock cycles, normal and stretched
	parameter int LP_CYCLES = `LP_INTERVAL_US * `CLK_MHZ,
	parameter int LP_LONG_CYCLES = `LP_LONG_INTERVAL_US * `CLK_MHZ
)(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// control bits from the management register file
	input wire pwr_ctrl_type ctrl_i,
	input wire logic sw_reset_i,
	input wire logic long_pulse_i,
	// line and negotiation status
	input wire logic autoneg_en_i,
	input wire logic link_up_i,
	input wire logic energy_det_i,
	// outputs, each straight from a flip-flop
	output var pwr_gate_type gate_o,
	output var logic link_pulse_o,
	output var logic soft_reset_o,
	output var logic mgmt_en_o,
	output var pwr_state_type state_o
);

	// ==============================================
	// mode qualification
	// ==============================================
	wire logic idle_line;
	wire logic want_psave;
	wire logic want_energy_pd;
	wire logic want_pdown;
	wire logic want_slow;
	wire logic mode_change;

	// autoneg and no link
	// the cable-driven modes must drop out at once when a partner shows up
	assign idle_line = autoneg_en_i & ~link_up_i;
	assign want_psave = ctrl_i.psave & idle_line;
	// a zero in the control bit asks for energy-detect power-down
	assign want_energy_pd = ~ctrl_i.energy_detect_powerdown_n & idle_line;
	assign want_pdown = ctrl_i.pdown;
	assign want_slow = ctrl_i.slow_osc;

	pwr_state_type state_q, state_d;
	logic wake_q;
	logic [31:0] lp_cnt_q;
	logic [3:0] rst_cnt_q;
	pwr_gate_type gate_d;

	// next state: power-down outranks the cable-driven modes
	// slow oscillator alone is held off: a live transceiver cannot run from it,
	// so it only takes over together with power-down
	always_comb
	begin
		if (want_pdown & want_slow)
			state_d = ST_SLOW;
		else if (want_pdown)
			state_d = ST_PDOWN;
		else if (want_energy_pd)
			state_d = ST_ENERGY_PD;
		else if (want_psave)
			state_d = ST_PSAVE;
		else
			state_d = ST_NORMAL;
	end

	// ==============================================
	// gate decode per state
	// ==============================================
	always_comb
	begin
		// everything on unless the mode below says otherwise
		gate_d = pwr_gate_type'(`GATE_ON);
		unique case (state_d)
			ST_NORMAL: ;
			ST_PSAVE:
			begin
				gate_d.rx_en = wake_q;
				gate_d.dsp_en = wake_q;
			end
			ST_ENERGY_PD:
			begin
				gate_d.rx_en = wake_q;
				gate_d.dsp_en = wake_q;
				gate_d.pll_en = ~ctrl_i.pll_off | wake_q;
			end
			ST_PDOWN, ST_SLOW:
			begin
				gate_d = '0;
				gate_d.ref_clk_sel = (state_d == ST_SLOW);
			end
		endcase
	end

	// ==============================================
	// state and gate registers
	// ==============================================
	// reset leaves all modes off
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= ST_NORMAL;
			gate_o <= pwr_gate_type'(`GATE_ON);
		end
		else
		begin
			state_q <= state_d;
			gate_o <= gate_d;
		end
	end
	assign state_o = state_q;

	// a new mode is asleep from its second cycle on; energy seen in the switching cycle is
	// not lost for long, since the detector keeps reporting it
	assign mode_change = (state_d != state_q);

	// energy wakes blocks, held while mode stays
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wake_q <= 1'h0;
		else if (mode_change)
			wake_q <= 1'h0;
		else if (energy_det_i)
			wake_q <= 1'h1;
	end

	// ==============================================
	// link pulse timer
	// ==============================================
	// wide counter so a stretched interval fits at the full clock rate
	wire logic [31:0] lp_limit;
	wire logic lp_active;
	wire logic lp_wrap;
	// longer interval in energy-detect when asked
	assign lp_limit = (state_q == ST_ENERGY_PD && long_pulse_i) ?
		32'(LP_LONG_CYCLES - 1) : 32'(LP_CYCLES - 1);
	// pulses only while waiting for a partner on an idle line
	assign lp_active = (state_q == ST_PSAVE) || (state_q == ST_ENERGY_PD);
	// >= rather than == so a shorter limit mid-count cannot be skipped
	assign lp_wrap = (lp_cnt_q >= lp_limit);

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lp_cnt_q <= 32'h0;
			link_pulse_o <= 1'h0;
		end
		else if (lp_active)
		begin
			link_pulse_o <= lp_wrap;
			lp_cnt_q <= lp_wrap ? 32'h0 : lp_cnt_q + 32'h1;
		end
		else
		begin
			lp_cnt_q <= 32'h0;
			link_pulse_o <= 1'h0;
		end
	end

	// ==============================================
	// software reset and management enable
	// ==============================================
	wire logic rst_take;
	wire logic rst_busy;
	// reset only honoured once slow and power-down cleared
	// a reset while still asleep would restart a part that is not yet clocked
	assign rst_take = sw_reset_i & ~want_slow & ~want_pdown;
	// counter holds the pulse on for the rest of its length
	assign rst_busy = (rst_cnt_q > 4'h1);

	// management side is never gated, so the host can always write its way out
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_cnt_q <= 4'h0;
			soft_reset_o <= 1'h0;
			mgmt_en_o <= 1'h0;
		end
		else
		begin
			mgmt_en_o <= 1'h1;
			if (rst_take)
				rst_cnt_q <= `SWRST_CYCLES;
			else if (rst_cnt_q != 4'h0)
				rst_cnt_q <= rst_cnt_q - 4'h1;
			soft_reset_o <= rst_take | rst_busy;
		end
	end

endmodule // phy_low_power_mode_control
`default_nettype wire

/* File: bench/lpm_assertions.sv */
// checker for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_chk
	import lpm_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// inputs and outputs watched
	input wire pwr_ctrl_type ctrl_i,
	input wire logic link_up_i,
	input wire logic energy_det_i,
	input wire pwr_gate_type gate_o,
	input wire logic soft_reset_o,
	input wire logic mgmt_en_o,
	input wire pwr_state_type state_o
);
	// ====================
	// one domain, so clock and reset are shared
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	AST_PD_IN: assert property (ctrl_i.pdown |=> state_o inside {ST_PDOWN, ST_SLOW})
		else $error("no power-down");
	AST_LINK: assert property (link_up_i && !ctrl_i.pdown |=> state_o == ST_NORMAL)
		else $error("saving with link");
	AST_PS: assert property (state_o == ST_PSAVE |-> gate_o.tx_en && gate_o.pll_en)
		else $error("saving gates");
	AST_ED: assert property (state_o == ST_ENERGY_PD && !gate_o.rx_en && $past(ctrl_i.pll_off)
		|-> !gate_o.pll_en && gate_o.tx_en)
		else $error("pll left on");
	AST_PD: assert property (state_o == ST_PDOWN |-> mgmt_en_o && !gate_o.tx_en)
		else $error("power-down gates");
	AST_PD_OUT: assert property ($fell(ctrl_i.pdown) |=> state_o != ST_PDOWN)
		else $error("stuck in power-down");
	// wake may take one extra cycle through its flag
	AST_WAKE: assert property (state_o == ST_PSAVE && energy_det_i ##1
		state_o == ST_PSAVE [*2] |-> gate_o.rx_en)
		else $error("no wake");
	AST_SRST: assert property ($rose(soft_reset_o) |-> soft_reset_o [*8] ##1 !soft_reset_o)
		else $error("reset length");
	cover property (state_o == ST_ENERGY_PD);
	cover property (state_o == ST_PSAVE && gate_o.rx_en);
	cover property (state_o == ST_SLOW);
	cover property ($rose(soft_reset_o));
endmodule // lpm_chk
bind phy_low_power_mode_control lpm_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.ctrl_i(ctrl_i), .link_up_i(link_up_i), .energy_det_i(energy_det_i), .gate_o(gate_o),
	.soft_reset_o(soft_reset_o), .mgmt_en_o(mgmt_en_o), .state_o(state_o));
`default_nettype wire

/* File: bench/mgmt_host.sv */
// management host model writing the control bits
`timescale 1ns/1ps
`default_nettype none
module mgmt_host
	import lpm_pkg::*;
(
	// clock in, control bits out
	input wire logic mclk_i,
	output var pwr_ctrl_type ctrl_o,
	output var logic sw_reset_o
);
	// ====================
	// power-up image: all modes off
	initial
	begin
		ctrl_o = 5'h08;
		sw_reset_o = 1'b0;
	end
	// one write, launched just after an edge
	task automatic put(input pwr_ctrl_type c, input logic r);
		@(posedge mclk_i);
		#1 ctrl_o = c;
		sw_reset_o = r;
	endtask
	task automatic leave_slow(input pwr_ctrl_type c);
		c.slow_osc = 1'b0;
		put(c, 1'b0);
		c.pdown = 1'b0;
		put(c, 1'b0);
		put(c, 1'b1);
		put(c, 1'b0);
	endtask
endmodule // mgmt_host
`default_nettype wire

/* File: bench/phy_low_power_mode_control_tb_top.sv */
// bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module phy_low_power_mode_control_tb_top;
	import lpm_pkg::*;
	logic mclk_i = 0, rst_n_i = 0, an = 1, lnk = 0, en = 0, lp = 0, swr, pul, srst, mg;
	pwr_ctrl_type ctrl;
	pwr_gate_type gate;
	pwr_state_type st;
	int fails = 0, n_checks = 0;
	localparam int LP_N = 4;
	localparam int LP_L = 8;
	// ====================
	initial forever #2.5 mclk_i = ~mclk_i;
	mgmt_host host (.mclk_i(mclk_i), .ctrl_o(ctrl), .sw_reset_o(swr));
	// short pulse counts keep the run brief
	phy_low_power_mode_control #(.LP_CYCLES(LP_N), .LP_LONG_CYCLES(LP_L)) dut (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .ctrl_i(ctrl), .sw_reset_i(swr), .long_pulse_i(lp),
		.autoneg_en_i(an), .link_up_i(lnk), .energy_det_i(en), .gate_o(gate),
		.link_pulse_o(pul), .soft_reset_o(srst), .mgmt_en_o(mg), .state_o(st));
	task automatic chk(input string nm, input logic [6:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic close_out;
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// cycles from one link pulse to the next, both waits bounded
	task automatic gap(output int g);
		int k;
		k = 0;
		while (pul !== 1'b1 && k < 20)
		begin
			cyc(1);
			k++;
		end
		g = 0;
		do
		begin
			cyc(1);
			g++;
		end
		while (pul !== 1'b1 && g < 20);
	endtask
	task automatic t_psave;
		host.put(5'h18, 1'b0);
		cyc(1);
		chk("ps", st, ST_PSAVE);
		chk("ps_rx", gate.rx_en, 1'b0);
		chk("ps_gate", gate, 7'h39);
		en = 1'b1;
		cyc(3);
		chk("wake", gate.rx_en, 1'b1);
		{en, lnk} = 2'h1;
		cyc(1);
		chk("link", st, ST_NORMAL);
		lnk = 1'b0;
	endtask
	task automatic t_energy;
		int n;
		host.put(5'h04, 1'b0);
		cyc(1);
		chk("ed", st, ST_ENERGY_PD);
		chk("ed_pll", {gate.tx_en, gate.rx_en, gate.pll_en}, 3'h4);
		chk("ed_gate", gate, 7'h31);
		gap(n);
		chk("pulses", 7'(n), 7'(LP_N));
		lp = 1'b1;
		gap(n);
		chk("pulses_long", 7'(n), 7'(LP_L));
		en = 1'b1;
		cyc(2);
		chk("ed_wake", {gate.rx_en, gate.pll_en}, 2'h3);
		{en, lp} = 2'h0;
	endtask
	task automatic t_pdown;
		host.put(5'h0A, 1'b0);
		cyc(1);
		chk("pd", st, ST_PDOWN);
		chk("pd_mg", {mg, gate.tx_en, gate.pll_en}, 3'h4);
		chk("pd_gate", gate, 7'h00);
		host.put(5'h0B, 1'b1);
		cyc(1);
		chk("slow", st, ST_SLOW);
		chk("refuse", srst, 1'b0);
		chk("slow_gate", gate, 7'h02);
		host.leave_slow(5'h0B);
		chk("exit", st, ST_NORMAL);
		chk("srst", srst, 1'b1);
	endtask
	// main sequence after a two-cycle reset
	initial
	begin
		cyc(2);
		rst_n_i = 1'b1;
		cyc(1);
		chk("rst", st, ST_NORMAL);
		chk("rst_gate", gate, 7'h7D);
		t_psave;
		t_energy;
		t_pdown;
		close_out;
	end
	// the sequence needs well under 150 cycles, the limit allows 400
	initial
	begin
		#2000;
		fails++;
		close_out;
	end
endmodule // phy_low_power_mode_control_tb_top
`default_nettype wire
